// [rtl/floppy_host_map.vh]
// Offsets, encodings and reset values for the floppy host register decode
`ifndef FLOPPY_HOST_MAP_VH
`define FLOPPY_HOST_MAP_VH

// Floppy register offsets from the programmed base
`define OFS_STATUS_A 3'h0
`define OFS_STATUS_B 3'h1
`define OFS_OUTPUT_CTRL 3'h2
`define OFS_TAPE_CTRL 3'h3
`define OFS_MAIN_STATUS 3'h4
`define OFS_DATA_PORT 3'h5
`define OFS_RESERVED 3'h6
`define OFS_INPUT_STATUS 3'h7

// Index port of the main and alternate configuration pairs; data port is one above
`define CFG_PORT_MAIN 16'h03f0
`define CFG_PORT_ALT 16'h0370

// Configuration state entry and exit keys
`define CFG_KEY_ENTER 8'h55
`define CFG_KEY_EXIT 8'haa

// Configuration register indices
`define CFG_IDX_MODE 8'h03
`define CFG_IDX_FORCE 8'h17
`define CFG_IDX_BASE 8'h20

// Mode and force configuration field positions
`define MODE_ALT_FLOPPY_BIT 0
`define MODE_STYLE_SEL_BIT 1
`define MODE_REG_SET_BIT 2
`define FORCE_WP_BIT 0

// Reset values and the output control gate bit position
`define MODE_RESET 8'h06
`define FORCE_RESET 8'h00
`define BASE_RESET 8'h00
`define OUTPUT_CTRL_RESET 8'h00
`define TAPE_CTRL_RESET 8'h00
`define RATE_RESET 8'h02
`define DMA_GATE_BIT 3

// Host interface style encodings
`define STYLE_PRIMARY 2'h0
`define STYLE_SECOND 2'h1
`define STYLE_COMPACT 2'h2

`endif

// [rtl/floppy_host_register_decode.v]
// Host register decode, configuration port and status A for the floppy block
// Operation
// - All host registers are eight bits
// - Config pair at 3F0 or 370, write only
// - Blocks disabled until base is programmed
// - Config changes only in configuration state
// - Alternate mode bit picks floppy mode
// - Any style works in either floppy mode
// - Two config bits decode host style
// - Primary: gate bit valid, tri-state, high polarity
// - Second: gate ignored, always drive, low polarity
// - Compact: gate valid, TC high, density low
// - Offsets 0 to 3 decode as listed
// - Offsets 4, 5, 7 split read and write
// - Status A readable in second, compact styles
// - Status A read in primary leaves bus floating
// - Second style status A bit layout
// - Bit 0 direction, high means inward
// - Bit 1 write protect low, forced too
// - Bit 2 index shown active low
// - Bit 3 head side active high
// - Bit 4 track zero active low
// - Bit 5 live step level
// - Bit 6 drive-2 flag reads one
// - Bit 7 mirrors interrupt output level
`timescale 1ns/100ps
`include "floppy_host_map.vh"

module floppy_host_register_decode #(
	parameter ADDR_W = 16
) (
	// Clock and reset
	input wire clock_in,
	input wire rst_n_in,
	// Host I/O bus pins
	input wire [ADDR_W-1:0] io_addr_in,
	input wire aen_in,
	input wire io_rd_n_in,
	input wire io_wr_n_in,
	input wire [7:0] io_data_in,
	output reg [7:0] io_data_out,
	output wire io_data_oe_out,
	// Strap choosing the configuration pair
	input wire cfg_port_alt_in,
	// Drive interface inputs
	input wire track_zero_n_in,
	input wire index_pulse_n_in,
	input wire write_protect_n_in,
	// Host terminal count pin
	input wire tc_pin_in,
	// Controller core signals, same clock
	input wire core_irq_in,
	input wire core_drq_in,
	input wire core_step_in,
	input wire core_dir_in,
	input wire core_head_side_in,
	input wire core_density_in,
	input wire [7:0] core_status_b_in,
	input wire [7:0] core_main_status_in,
	input wire [7:0] core_data_in,
	input wire [7:0] core_input_status_in,
	// Core data port strobes
	output reg data_port_wr_out,
	output reg data_port_rd_out,
	output reg [7:0] data_port_wdata_out,
	// Control registers toward the core
	output reg [7:0] output_ctrl_out,
	output reg [7:0] tape_ctrl_out,
	output reg [7:0] rate_select_out,
	output reg [7:0] rate_config_out,
	output reg rate_select_wr_out,
	// Mode and pin conditioning
	output wire [1:0] host_style_out,
	output wire alternate_floppy_mode_out,
	output wire config_state_out,
	output wire disk_irq_out,
	output wire disk_irq_oe_out,
	output wire drq_out,
	output wire drq_oe_out,
	output wire tc_active_out,
	output wire density_select_out
);

	// Style from the style select bit and register set select bit
	function [1:0] style_of;
		input style_sel;
		input reg_set_select;
		begin
			if (style_sel && reg_set_select)
				style_of = `STYLE_PRIMARY;
			else if (!style_sel && reg_set_select)
				style_of = `STYLE_SECOND;
			else
				style_of = `STYLE_COMPACT;
		end
	endfunction

	// Apply pin polarity, one meaning active high
	function pol;
		input value;
		input active_high;
		begin
			pol = active_high ? value : ~value;
		end
	endfunction

	// Reset release stages
	reg rst_meta_ff;
	reg rst_sync_ff;
	wire rst_n;

	// Synchroniser stages for the bus and drive pins
	reg [ADDR_W+15:0] pin_meta_ff;
	reg [ADDR_W+15:0] pin_sync_ff;
	wire [ADDR_W-1:0] addr;
	wire aen;
	wire rd_n;
	wire wr_n;
	wire [7:0] wdata;
	wire strap_alt;
	wire trk0_n;
	wire index_n;
	wire wp_n;
	wire tc_pin;

	// Strobe history for edge detection
	reg rd_n_prev_ff;
	reg wr_n_prev_ff;
	reg [ADDR_W-1:0] addr_hold_ff;
	wire rd_start;
	wire wr_end;

	// Configuration state and registers
	reg cfg_state_ff;
	reg port_alt_ff;
	reg [7:0] cfg_index_ff;
	reg [7:0] cfg_mode_ff;
	reg [7:0] cfg_force_ff;
	reg [7:0] cfg_base_ff;

	// Compact style step latch
	reg step_latch_ff;
	reg step_prev_ff;

	// Decode terms
	wire [ADDR_W-1:0] cfg_base_addr;
	wire cfg_index_hit;
	wire cfg_data_hit;
	wire block_enabled;
	wire block_hit;
	wire [2:0] offset;
	wire [1:0] style;
	wire primary;
	wire second;
	wire dma_gate;
	wire wp_n_eff;
	reg [7:0] status_a;
	reg [7:0] rd_mux;
	reg rd_valid;

	// Hold reset low until two edges after the pin releases
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end
	assign rst_n = rst_sync_ff;

	// Two-stage synchroniser for every pin from outside the clock domain
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_ff <= {(ADDR_W+16){1'b1}};
			pin_sync_ff <= {(ADDR_W+16){1'b1}};
		end else begin
			pin_meta_ff <= {io_addr_in, aen_in, io_rd_n_in, io_wr_n_in, io_data_in,
				cfg_port_alt_in, track_zero_n_in, index_pulse_n_in, write_protect_n_in,
				tc_pin_in};
			pin_sync_ff <= pin_meta_ff;
		end
	end
	assign addr = pin_sync_ff[ADDR_W+15:16];
	assign aen = pin_sync_ff[15];
	assign rd_n = pin_sync_ff[14];
	assign wr_n = pin_sync_ff[13];
	assign wdata = pin_sync_ff[12:5];
	assign strap_alt = pin_sync_ff[4];
	assign trk0_n = pin_sync_ff[3];
	assign index_n = pin_sync_ff[2];
	assign wp_n = pin_sync_ff[1];
	assign tc_pin = pin_sync_ff[0];

	// Edge history; address held from the cycle the write was still active
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			rd_n_prev_ff <= 1'b1;
			wr_n_prev_ff <= 1'b1;
			addr_hold_ff <= {ADDR_W{1'b0}};
		end else begin
			rd_n_prev_ff <= rd_n;
			wr_n_prev_ff <= wr_n;
			addr_hold_ff <= addr;
		end
	end
	// Writes act at release so address and data have settled
	assign rd_start = rd_n_prev_ff && !rd_n && !aen;
	assign wr_end = !wr_n_prev_ff && wr_n && !aen;

	// Configuration pair chosen by the strap as last sampled outside configuration state
	assign cfg_base_addr = port_alt_ff ? `CFG_PORT_ALT : `CFG_PORT_MAIN;
	assign cfg_index_hit = addr_hold_ff == cfg_base_addr;
	assign cfg_data_hit = addr_hold_ff == (cfg_base_addr | 16'h0001);

	// Base zero after power-up leaves the block dark
	assign block_enabled = cfg_base_ff[7:1] != 7'h00;
	// Base register holds address bits 9 to 2; bit 0 of it is unused
	assign block_hit = block_enabled && (addr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}})
		&& (addr[9:3] == cfg_base_ff[7:1]);
	assign offset = addr[2:0];

	// Style and floppy mode are independent fields
	assign style = style_of(cfg_mode_ff[`MODE_STYLE_SEL_BIT],
		cfg_mode_ff[`MODE_REG_SET_BIT]);
	assign primary = style == `STYLE_PRIMARY;
	assign second = style == `STYLE_SECOND;
	assign host_style_out = style;
	assign alternate_floppy_mode_out = cfg_mode_ff[`MODE_ALT_FLOPPY_BIT];
	assign config_state_out = cfg_state_ff;

	// Gate bit only counts outside the second style
	assign dma_gate = second | output_ctrl_out[`DMA_GATE_BIT];
	assign disk_irq_out = core_irq_in;
	assign drq_out = core_drq_in;
	assign disk_irq_oe_out = dma_gate;
	assign drq_oe_out = dma_gate;
	// Terminal count is ignored while the gate holds the pins off
	assign tc_active_out = dma_gate & pol(tc_pin, !second);
	assign density_select_out = pol(core_density_in, primary);

	// Forced protect reads as protected regardless of the drive
	assign wp_n_eff = wp_n & ~cfg_force_ff[`FORCE_WP_BIT];

	// Configuration port: entry key, index, data, exit key
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			cfg_state_ff <= 1'b0;
			port_alt_ff <= 1'b0;
			cfg_index_ff <= 8'h00;
			cfg_mode_ff <= `MODE_RESET;
			cfg_force_ff <= `FORCE_RESET;
			cfg_base_ff <= `BASE_RESET;
		end else begin
			// Strap sampled while idle, so it is caught after release
			if (!cfg_state_ff)
				port_alt_ff <= strap_alt;
			if (wr_end && cfg_index_hit) begin
				// Index port also carries the keys
				if (!cfg_state_ff && wdata == `CFG_KEY_ENTER)
					cfg_state_ff <= 1'b1;
				else if (cfg_state_ff && wdata == `CFG_KEY_EXIT)
					cfg_state_ff <= 1'b0;
				else if (cfg_state_ff)
					cfg_index_ff <= wdata;
			end else if (wr_end && cfg_data_hit && cfg_state_ff) begin
				case (cfg_index_ff)
					`CFG_IDX_MODE: begin
						cfg_mode_ff <= wdata;
					end
					`CFG_IDX_FORCE: begin
						cfg_force_ff <= wdata;
					end
					`CFG_IDX_BASE: begin
						cfg_base_ff <= wdata;
					end
					default: begin
						// Unknown index is dropped
						cfg_index_ff <= cfg_index_ff;
					end
				endcase
			end
		end
	end

	// Floppy register writes; the block keeps working in config state
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			output_ctrl_out <= `OUTPUT_CTRL_RESET;
			tape_ctrl_out <= `TAPE_CTRL_RESET;
			rate_select_out <= `RATE_RESET;
			rate_config_out <= `RATE_RESET;
			rate_select_wr_out <= 1'b0;
			data_port_wr_out <= 1'b0;
			data_port_wdata_out <= 8'h00;
		end else begin
			rate_select_wr_out <= 1'b0;
			data_port_wr_out <= 1'b0;
			// Address from the held copy matches the active write cycle
			if (wr_end && block_enabled && addr_hold_ff[9:3] == cfg_base_ff[7:1]
				&& addr_hold_ff[ADDR_W-1:10] == {(ADDR_W-10){1'b0}}) begin
				case (addr_hold_ff[2:0])
					`OFS_OUTPUT_CTRL: begin
						output_ctrl_out <= wdata;
					end
					`OFS_TAPE_CTRL: begin
						tape_ctrl_out <= wdata;
					end
					`OFS_MAIN_STATUS: begin
						rate_select_out <= wdata;
						rate_select_wr_out <= 1'b1;
					end
					`OFS_DATA_PORT: begin
						data_port_wdata_out <= wdata;
						data_port_wr_out <= 1'b1;
					end
					`OFS_INPUT_STATUS: begin
						rate_config_out <= wdata;
					end
					default: begin
						// Status A, status B and reserved offsets ignore writes
						data_port_wr_out <= 1'b0;
					end
				endcase
			end
		end
	end

	// Compact style step latch, cleared by an input status read
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			step_latch_ff <= 1'b0;
			step_prev_ff <= 1'b0;
		end else begin
			step_prev_ff <= core_step_in;
			// A new step pulse beats a clearing read in the same cycle
			if (core_step_in && !step_prev_ff)
				step_latch_ff <= 1'b1;
			else if (rd_start && block_hit && offset == `OFS_INPUT_STATUS)
				step_latch_ff <= 1'b0;
		end
	end

	// Status A layout per style
	always @* begin
		status_a = 8'h00;
		if (second) begin
			status_a[7] = core_irq_in;
			status_a[6] = 1'b1;
			status_a[5] = core_step_in;
			status_a[4] = trk0_n;
			status_a[3] = core_head_side_in;
			status_a[2] = index_n;
			status_a[1] = wp_n_eff;
			status_a[0] = core_dir_in;
		end else begin
			// Compact layout uses the opposite senses
			status_a[7] = core_irq_in;
			status_a[6] = core_drq_in;
			status_a[5] = step_latch_ff;
			status_a[4] = ~trk0_n;
			status_a[3] = ~core_head_side_in;
			status_a[2] = ~index_n;
			status_a[1] = ~wp_n_eff;
			status_a[0] = ~core_dir_in;
		end
	end

	// Read data select; reserved offset and config ports stay undriven
	always @* begin
		rd_mux = 8'h00;
		rd_valid = 1'b0;
		case (offset)
			`OFS_STATUS_A: begin
				rd_mux = status_a;
				rd_valid = !primary;
			end
			`OFS_STATUS_B: begin
				rd_mux = core_status_b_in;
				rd_valid = !primary;
			end
			`OFS_OUTPUT_CTRL: begin
				rd_mux = output_ctrl_out;
				rd_valid = 1'b1;
			end
			`OFS_TAPE_CTRL: begin
				rd_mux = tape_ctrl_out;
				rd_valid = 1'b1;
			end
			`OFS_MAIN_STATUS: begin
				rd_mux = core_main_status_in;
				rd_valid = 1'b1;
			end
			`OFS_DATA_PORT: begin
				rd_mux = core_data_in;
				rd_valid = 1'b1;
			end
			`OFS_INPUT_STATUS: begin
				rd_mux = core_input_status_in;
				rd_valid = 1'b1;
			end
			default: begin
				// Reserved location answers nothing
				rd_valid = 1'b0;
			end
		endcase
	end

	// Read data register and core read strobe
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			io_data_out <= 8'h00;
			data_port_rd_out <= 1'b0;
		end else begin
			io_data_out <= rd_mux;
			data_port_rd_out <= rd_start && block_hit && offset == `OFS_DATA_PORT;
		end
	end

	// Drive the bus only during a read of a valid location
	reg oe_ff;
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n)
			oe_ff <= 1'b0;
		else
			oe_ff <= !rd_n && !aen && block_hit && rd_valid;
	end
	assign io_data_oe_out = oe_ff;

endmodule

// [verification/floppy_host_checker_assertions.sv]
// Concurrent checks on the floppy host register decode ports
`timescale 1ns/100ps
`include "floppy_host_map.vh"

module floppy_host_checker #(
	parameter ADDR_W = 16
) (
	// Clock and reset
	input wire clock_in,
	input wire rst_n_in,
	// Host bus
	input wire [ADDR_W-1:0] io_addr_in,
	input wire io_rd_n_in,
	input wire io_data_oe_out,
	// Pins and modes
	input wire tc_pin_in,
	input wire core_density_in,
	input wire [7:0] output_ctrl_out,
	input wire rate_select_wr_out,
	input wire [1:0] host_style_out,
	input wire config_state_out,
	input wire disk_irq_oe_out,
	input wire drq_oe_out,
	input wire tc_active_out,
	input wire density_select_out
);
	// Settle counter; syncs and internal reset need a few edges after release
	reg [2:0] up_ff;
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in)
			up_ff <= 3'h0;
		else if (up_ff != 3'h7)
			up_ff <= up_ff + 3'h1;
	end

	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in || up_ff != 3'h7);

	// TC pin unchanged long enough to cross its synchroniser
	sequence tc_steady;
		$stable(tc_pin_in) [*3];
	endsequence
	// Status A read held in primary style
	sequence sra_read_primary;
		(host_style_out == `STYLE_PRIMARY && io_addr_in[2:0] == 3'h0 && !io_rd_n_in) [*6];
	endsequence
	// No read strobe for a while
	sequence rd_idle;
		io_rd_n_in [*6];
	endsequence

	AST_OE_SECOND: assert property (host_style_out == `STYLE_SECOND |-> disk_irq_oe_out && drq_oe_out)
		else $error("irq or drq floating in second style");
	AST_OE_GATE: assert property (host_style_out != `STYLE_SECOND |->
		disk_irq_oe_out == output_ctrl_out[`DMA_GATE_BIT] && drq_oe_out == disk_irq_oe_out)
		else $error("irq or drq enable not following gate bit");
	AST_DENSITY: assert property (density_select_out ==
		(host_style_out == `STYLE_PRIMARY ? core_density_in : !core_density_in))
		else $error("density polarity wrong for style");
	AST_TC: assert property (tc_steady |-> tc_active_out ==
		(disk_irq_oe_out && (host_style_out == `STYLE_SECOND ? !tc_pin_in : tc_pin_in)))
		else $error("terminal count polarity or gating wrong");
	AST_FLOAT_PRIMARY: assert property (sra_read_primary |-> !io_data_oe_out)
		else $error("status A driven in primary style");
	AST_READ_LATENCY: assert property ($rose(io_data_oe_out) |->
		!$past(io_rd_n_in, 2) && !$past(io_rd_n_in, 3))
		else $error("bus driven without a read");
	AST_OE_IDLE: assert property (rd_idle |-> !io_data_oe_out)
		else $error("bus still driven after read ended");
	AST_STYLE_CFG: assert property ($changed(host_style_out) |-> $past(config_state_out))
		else $error("style changed outside configuration state");
	AST_RATE_PULSE: assert property (rate_select_wr_out |=> !rate_select_wr_out)
		else $error("rate write pulse longer than one cycle");
endmodule

bind floppy_host_register_decode floppy_host_checker #(.ADDR_W(ADDR_W)) floppy_host_checker_i (
	.clock_in(clock_in), .rst_n_in(rst_n_in), .io_addr_in(io_addr_in),
	.io_rd_n_in(io_rd_n_in), .io_data_oe_out(io_data_oe_out), .tc_pin_in(tc_pin_in),
	.core_density_in(core_density_in), .output_ctrl_out(output_ctrl_out),
	.rate_select_wr_out(rate_select_wr_out), .host_style_out(host_style_out),
	.config_state_out(config_state_out), .disk_irq_oe_out(disk_irq_oe_out),
	.drq_oe_out(drq_oe_out), .tc_active_out(tc_active_out),
	.density_select_out(density_select_out)
);

// [verification/io_host_model.sv]
// Host processor model driving the I/O bus pins
`timescale 1ns/100ps

module io_host_model (
	// Clock
	input wire clock_in,
	// Bus pins toward the device
	output reg [15:0] io_addr_out,
	output reg aen_out,
	output reg io_rd_n_out,
	output reg io_wr_n_out,
	output reg [7:0] io_data_out,
	// Read answer from the device
	input wire [7:0] io_rdata_in,
	input wire io_rdata_oe_in
);
	// Idle bus at time zero
	initial begin
		io_addr_out = 16'h0000;
		aen_out = 1'b0;
		io_rd_n_out = 1'b1;
		io_wr_n_out = 1'b1;
		io_data_out = 8'h00;
	end

	// Write; data held past release since the device samples late
	task wr(input [15:0] a, input [7:0] d);
		begin
			@(posedge clock_in);
			io_addr_out <= a;
			io_data_out <= d;
			io_wr_n_out <= 1'b0;
			repeat (4) @(posedge clock_in);
			io_wr_n_out <= 1'b1;
			repeat (4) @(posedge clock_in);
			io_data_out <= ~d; // Released bus shows no stale value
		end
	endtask

	// Read; answer taken at the edge of release, then idle gap
	task rd(input [15:0] a, output [7:0] d, output oe);
		begin
			@(posedge clock_in);
			io_addr_out <= a;
			io_rd_n_out <= 1'b0;
			repeat (6) @(posedge clock_in);
			d = io_rdata_in;
			oe = io_rdata_oe_in;
			io_rd_n_out <= 1'b1;
			repeat (6) @(posedge clock_in);
		end
	endtask
endmodule

// [verification/tb_floppy_host_register_decode.sv]
// Self-checking testbench for the floppy host register decode
`timescale 1ns/100ps
`include "floppy_host_map.vh"

module tb_floppy_host_register_decode;
	localparam [15:0] BASE = 16'h03c0; // Floppy base programmed by the bench
	reg clock_in = 1'b0;
	reg rst_n_in = 1'b0;
	reg [6:0] pins = 7'h00; // irq, step, trk0_n, head, index_n, wp_n, dir
	reg tc = 1'b0;
	reg dens = 1'b0;
	reg strap = 1'b0; // Configuration pair strap
	integer n_wr = 0; // Data port write pulse cycles
	integer n_rd = 0; // Data port read pulse cycles
	integer n_rate = 0; // Rate select write pulse cycles
	wire irq_o, drq_o, dp_wr, dp_rd, rate_wr;
	wire [7:0] octl, tctl;
	integer num_errors = 0;
	integer checked = 0;
	integer i;
	reg [7:0] rd;
	reg oe;
	reg [1:0] s;
	wire [15:0] io_addr;
	wire aen, io_rd_n, io_wr_n, io_oe, alt, cfg_st, irq_oe, drq_oe, tc_act, dens_o;
	wire [7:0] io_wdata, io_rdata, rsel, rcfg, wdat;
	wire [1:0] style;

	// Free-running 100 MHz clock
	always #5 clock_in = ~clock_in;

	// Count pulse cycles so width and number are both judged
	always @(posedge clock_in) begin
		if (dp_wr)
			n_wr <= n_wr + 1;
		if (dp_rd)
			n_rd <= n_rd + 1;
		if (rate_wr)
			n_rate <= n_rate + 1;
	end

	io_host_model io_host_model_i (.clock_in(clock_in), .io_addr_out(io_addr), .aen_out(aen),
		.io_rd_n_out(io_rd_n), .io_wr_n_out(io_wr_n), .io_data_out(io_wdata),
		.io_rdata_in(io_rdata), .io_rdata_oe_in(io_oe));

	floppy_host_register_decode floppy_host_register_decode_i (.clock_in(clock_in),
		.rst_n_in(rst_n_in), .io_addr_in(io_addr), .aen_in(aen), .io_rd_n_in(io_rd_n),
		.io_wr_n_in(io_wr_n), .io_data_in(io_wdata), .io_data_out(io_rdata),
		.io_data_oe_out(io_oe), .cfg_port_alt_in(strap), .track_zero_n_in(pins[4]),
		.index_pulse_n_in(pins[2]), .write_protect_n_in(pins[1]), .tc_pin_in(tc),
		.core_irq_in(pins[6]), .core_drq_in(pins[6]), .core_step_in(pins[5]),
		.core_dir_in(pins[0]), .core_head_side_in(pins[3]), .core_density_in(dens),
		.core_status_b_in(8'h3c), .core_main_status_in(8'h90), .core_data_in(8'h6e),
		.core_input_status_in(8'h81), .data_port_wr_out(dp_wr), .data_port_rd_out(dp_rd),
		.data_port_wdata_out(wdat), .output_ctrl_out(octl), .tape_ctrl_out(tctl),
		.rate_select_out(rsel), .rate_config_out(rcfg), .rate_select_wr_out(rate_wr),
		.host_style_out(style), .alternate_floppy_mode_out(alt), .config_state_out(cfg_st),
		.disk_irq_out(irq_o), .disk_irq_oe_out(irq_oe), .drq_out(drq_o), .drq_oe_out(drq_oe),
		.tc_active_out(tc_act), .density_select_out(dens_o));

	// Shared compare with count and report
	task chk(input [7:0] got, input [7:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask

	// Configuration access: enter, index, data, exit
	task cfg(input [7:0] idx, input [7:0] val);
		begin
			io_host_model_i.wr(`CFG_PORT_MAIN, `CFG_KEY_ENTER);
			chk(8'(cfg_st), 8'h01);
			io_host_model_i.wr(`CFG_PORT_MAIN, idx);
			io_host_model_i.wr(`CFG_PORT_MAIN + 16'h0001, val);
			io_host_model_i.wr(`CFG_PORT_MAIN, `CFG_KEY_EXIT);
			chk(8'(cfg_st), 8'h00);
		end
	endtask

	// Block answers nothing before its base is set
	task t_disabled;
		begin
			io_host_model_i.rd(BASE, rd, oe);
			chk(8'(oe), 8'h00);
		end
	endtask

	// Strap moves the configuration pair; the main pair then stays deaf
	task t_alt_port;
		begin
			@(posedge clock_in);
			strap <= 1'b1;
			repeat (4) @(posedge clock_in);
			io_host_model_i.wr(`CFG_PORT_MAIN, `CFG_KEY_ENTER);
			chk(8'(cfg_st), 8'h00);
			io_host_model_i.wr(`CFG_PORT_ALT, `CFG_KEY_ENTER);
			chk(8'(cfg_st), 8'h01);
			io_host_model_i.wr(`CFG_PORT_ALT, `CFG_KEY_EXIT);
			chk(8'(cfg_st), 8'h00);
			strap <= 1'b0;
			repeat (4) @(posedge clock_in);
		end
	endtask

	// Writes outside configuration state leave the mode alone
	task t_locked;
		begin
			io_host_model_i.wr(`CFG_PORT_MAIN, `CFG_IDX_MODE);
			io_host_model_i.wr(`CFG_PORT_MAIN + 16'h0001, 8'h06);
			chk(8'(style), 8'(`STYLE_SECOND));
		end
	endtask

	// Second style status A layout with every bit but bit 6 at both levels
	task t_status_a(input [6:0] p);
		begin
			@(posedge clock_in);
			pins <= p;
			repeat (4) @(posedge clock_in);
			io_host_model_i.rd(BASE, rd, oe);
			chk(8'(oe), 8'h01);
			chk(rd, {p[6], 1'b1, p[5:0]});
			chk(8'({irq_o, drq_o}), {6'h00, p[6], p[6]});
		end
	endtask

	// Forced write protect pulls bit 1 low
	task t_force_wp;
		begin
			@(posedge clock_in);
			pins <= 7'h02;
			cfg(`CFG_IDX_FORCE, 8'h01);
			io_host_model_i.rd(BASE, rd, oe);
			chk(8'(rd[1]), 8'h00);
			cfg(`CFG_IDX_FORCE, 8'h00);
			io_host_model_i.rd(BASE, rd, oe);
			chk(8'(rd[1]), 8'h01);
		end
	endtask

	// Offset map, split read and write places, reserved offset
	task t_regs;
		begin
			io_host_model_i.wr(BASE + 16'h2, 8'h08);
			io_host_model_i.rd(BASE + 16'h2, rd, oe);
			chk(rd, 8'h08);
			chk(octl, 8'h08);
			io_host_model_i.wr(BASE + 16'h3, 8'h5a);
			chk(tctl, 8'h5a);
			io_host_model_i.rd(BASE + 16'h3, rd, oe);
			chk(rd, 8'h5a);
			io_host_model_i.rd(BASE + 16'h1, rd, oe);
			chk(rd, 8'h3c);
			io_host_model_i.wr(BASE + 16'h4, 8'h01);
			chk(rsel, 8'h01);
			io_host_model_i.wr(BASE + 16'h7, 8'h03);
			chk(rcfg, 8'h03);
			io_host_model_i.wr(BASE + 16'h5, 8'hc3);
			chk(wdat, 8'hc3);
			io_host_model_i.rd(BASE + 16'h4, rd, oe);
			chk(rd, 8'h90);
			io_host_model_i.rd(BASE + 16'h5, rd, oe);
			chk(rd, 8'h6e);
			io_host_model_i.rd(BASE + 16'h7, rd, oe);
			chk(rd, 8'h81);
			io_host_model_i.rd(BASE + 16'h6, rd, oe);
			chk(8'(oe), 8'h00);
			chk(8'(n_rate), 8'h01);
			chk(8'(n_wr), 8'h01);
			chk(8'(n_rd), 8'h01);
		end
	endtask

	// All six style and floppy mode pairs, then gate bit off
	task t_modes;
		begin
			@(posedge clock_in);
			tc <= 1'b1;
			dens <= 1'b1;
			for (i = 0; i < 6; i = i + 1) begin
				s = 2'(i % 3);
				cfg(`CFG_IDX_MODE, {5'h00, s != 2'h2, s == 2'h0, i > 2});
				repeat (4) @(posedge clock_in);
				chk(8'(style), 8'(s));
				chk(8'(alt), 8'(i > 2));
				chk(8'(dens_o), 8'(s == 2'h0));
				chk(8'(tc_act), 8'(s != 2'h1));
			end
			io_host_model_i.wr(BASE + 16'h2, 8'h00);
			chk(8'({irq_oe, drq_oe, tc_act}), 8'h00);
			cfg(`CFG_IDX_MODE, 8'h04);
			chk(8'({irq_oe, drq_oe}), 8'h03);
			cfg(`CFG_IDX_MODE, 8'h06);
			chk(8'(irq_oe), 8'h00);
		end
	endtask

	// Status A read in primary style leaves the bus floating
	task t_float;
		begin
			io_host_model_i.rd(BASE, rd, oe);
			chk(8'(oe), 8'h00);
		end
	endtask

	// Verdict and end of run
	task stop_test;
		begin
			$display("errors %0d checks %0d", num_errors, checked);
			if (num_errors == 0 && checked > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge clock_in);
		rst_n_in <= 1'b1;
		repeat (6) @(posedge clock_in);
		t_disabled;
		t_alt_port;
		cfg(`CFG_IDX_BASE, 8'hf0);
		cfg(`CFG_IDX_MODE, 8'h04);
		t_locked;
		t_status_a(7'h55);
		t_status_a(7'h2a);
		t_force_wp;
		t_regs;
		t_modes;
		t_float;
		stop_test;
	end

	// Watchdog; the run needs well under a tenth of this
	initial begin
		#200000;
		num_errors = num_errors + 1;
		stop_test;
	end
endmodule
